// ==== src/wfd_pkg.sv ====
package wfd_pkg;
	localparam int WORD_W = 16;
	localparam int BYTE_W = 8;
	localparam int DWORD_W = 32;
	localparam int SIGN_BIT = 15;
	localparam int EXP_SIGN_BIT = 0;
	localparam int EXP_LSB = 1;
	localparam int EXP_MSB = 7;
	localparam int EXP_W = 7;
	localparam int SP_MANT_W = 23;
	localparam int DP_MANT_W = 55;
	localparam int FP_WORDS = 4;
	localparam int FP_W = FP_WORDS * WORD_W;
	localparam logic [WORD_W-1:0] WORD_ZERO = 16'h0000;
	localparam logic [BYTE_W-1:0] BYTE_ZERO = 8'h00;
	localparam logic [DWORD_W-1:0] INT16_MAX_EXT = 32'h00007FFF;
	localparam logic [DWORD_W-1:0] INT16_MIN_EXT = 32'hFFFF8000;
	localparam logic [DWORD_W-1:0] INT32_MAX = 32'h7FFFFFFF;
	localparam logic [DWORD_W-1:0] INT32_MIN = 32'h80000000;

	typedef enum logic [2:0] {
		TX_IDLE = 3'b001,
		TX_HI = 3'b010,
		TX_LO = 3'b100
	} wfd_tx_state_t;

	typedef struct packed {
		logic mant_sign;
		logic [DP_MANT_W-1:0] mant;
		logic exp_sign;
		logic [EXP_W-1:0] exp;
	} wfd_fp_fields_t;

	typedef struct packed {
		logic [WORD_W-1:0] msw;
		logic [WORD_W-1:0] lsw;
	} wfd_word_pair_t;

	localparam wfd_fp_fields_t FP_FIELDS_ZERO = '0;

	function automatic logic wfd_sign_of(input logic [WORD_W-1:0] w);
		return w[SIGN_BIT];
	endfunction

	function automatic logic [DWORD_W-1:0] wfd_sext16(
		input logic [WORD_W-1:0] w);
		return {{(DWORD_W-WORD_W){wfd_sign_of(w)}}, w};
	endfunction
endpackage

// ==== src/wfd_word_format_datapath.sv ====
`timescale 1ns/10ps
// Summary of operation
// - words are 16 bits, bit 0 least significant
// - bit 15 is sign, one means negative
// - integers whole, binary point right of bit 0
// - byte transfer sends high byte first
// - hardware packs two received bytes per word
// - double integer sign in msw bit 15
// - float signs bit15 msw, bit0 lsw; exponent bits 1-7
// - single float: 23-bit mantissa, 7-bit exponent, signs
// - double float: 55-bit mantissa, exponent in lsw
// - negative mantissa, exponent each two's complement
// - msw to first accumulator, lsw to second
// - ranges 16-bit and 32-bit two's complement
module wfd_word_format_datapath
	import wfd_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic tx_load,
	input wire logic [wfd_pkg::WORD_W-1:0] tx_word,
	output logic tx_busy_ff,
	output logic tx_byte_valid_ff,
	output logic [wfd_pkg::BYTE_W-1:0] tx_byte_ff,
	input wire logic pack_en,
	input wire logic rx_byte_valid,
	input wire logic [wfd_pkg::BYTE_W-1:0] rx_byte,
	output logic rx_word_valid_ff,
	output logic [wfd_pkg::WORD_W-1:0] rx_word_ff,
	output logic rx_half_ff,
	input wire logic [wfd_pkg::WORD_W-1:0] int_word,
	output logic int_neg_ff,
	output logic [wfd_pkg::DWORD_W-1:0] int_ext_ff,
	input wire wfd_pkg::wfd_word_pair_t dint_in,
	output logic dint_neg_ff,
	output logic [wfd_pkg::DWORD_W-1:0] dint_value_ff,
	output logic dint_fits16_ff,
	input wire logic [wfd_pkg::FP_W-1:0] fp_in,
	input wire logic fp_in_double,
	output wfd_pkg::wfd_fp_fields_t fp_fields_ff,
	output logic signed [wfd_pkg::EXP_W:0] fp_exp_value_ff,
	input wire wfd_pkg::wfd_fp_fields_t fp_pack_in,
	input wire logic fp_pack_double,
	output logic [wfd_pkg::FP_W-1:0] fp_packed_ff,
	input wire logic acc_load,
	input wire logic acc_sel_fp,
	output logic [wfd_pkg::WORD_W-1:0] acc_a_ff,
	output logic [wfd_pkg::WORD_W-1:0] acc_b_ff
);
	import wfd_pkg::*;

	// byte serialiser
	wfd_tx_state_t tx_state_ff;
	wfd_tx_state_t nxt_tx_state;
	logic [BYTE_W-1:0] tx_low_ff;
	logic [BYTE_W-1:0] nxt_tx_low;
	logic nxt_tx_busy;
	logic nxt_tx_byte_valid;
	logic [BYTE_W-1:0] nxt_tx_byte;

	always_comb
	begin
		nxt_tx_state = tx_state_ff;
		nxt_tx_low = tx_low_ff;
		nxt_tx_byte_valid = 1'b0;
		nxt_tx_byte = tx_byte_ff;
		case (tx_state_ff)
			TX_IDLE:
			begin
				if (tx_load)
				begin
					nxt_tx_state = TX_HI;
					nxt_tx_byte = tx_word[WORD_W-1:BYTE_W];
					nxt_tx_low = tx_word[BYTE_W-1:0];
					nxt_tx_byte_valid = 1'b1;
				end
			end
			TX_HI:
			begin
				nxt_tx_state = TX_LO;
				nxt_tx_byte = tx_low_ff;
				nxt_tx_byte_valid = 1'b1;
			end
			TX_LO:
			begin
				nxt_tx_state = TX_IDLE;
			end
			default:
			begin
				nxt_tx_state = TX_IDLE;
			end
		endcase
		nxt_tx_busy = (nxt_tx_state != TX_IDLE);
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			tx_state_ff <= TX_IDLE;
			tx_low_ff <= BYTE_ZERO;
			tx_busy_ff <= 1'b0;
			tx_byte_valid_ff <= 1'b0;
			tx_byte_ff <= BYTE_ZERO;
		end
		else
		begin
			tx_state_ff <= nxt_tx_state;
			tx_low_ff <= nxt_tx_low;
			tx_busy_ff <= nxt_tx_busy;
			tx_byte_valid_ff <= nxt_tx_byte_valid;
			tx_byte_ff <= nxt_tx_byte;
		end
	end

	// byte packer: first byte received is the high-order byte
	logic [BYTE_W-1:0] rx_hold_ff;
	logic [BYTE_W-1:0] nxt_rx_hold;
	logic nxt_rx_half;
	logic nxt_rx_word_valid;
	logic [WORD_W-1:0] nxt_rx_word;

	always_comb
	begin
		nxt_rx_hold = rx_hold_ff;
		nxt_rx_half = rx_half_ff;
		nxt_rx_word_valid = 1'b0;
		nxt_rx_word = rx_word_ff;
		if (!pack_en)
		begin
			nxt_rx_half = 1'b0;
			if (rx_byte_valid)
			begin
				// unpacked mode: software does the packing
				nxt_rx_word = {BYTE_ZERO, rx_byte};
				nxt_rx_word_valid = 1'b1;
			end
		end
		else if (rx_byte_valid)
		begin
			if (!rx_half_ff)
			begin
				nxt_rx_hold = rx_byte;
				nxt_rx_half = 1'b1;
			end
			else
			begin
				nxt_rx_word = {rx_hold_ff, rx_byte};
				nxt_rx_word_valid = 1'b1;
				nxt_rx_half = 1'b0;
			end
		end
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			rx_hold_ff <= BYTE_ZERO;
			rx_half_ff <= 1'b0;
			rx_word_valid_ff <= 1'b0;
			rx_word_ff <= WORD_ZERO;
		end
		else
		begin
			rx_hold_ff <= nxt_rx_hold;
			rx_half_ff <= nxt_rx_half;
			rx_word_valid_ff <= nxt_rx_word_valid;
			rx_word_ff <= nxt_rx_word;
		end
	end

	// integer decode
	logic nxt_int_neg;
	logic [DWORD_W-1:0] nxt_int_ext;
	logic nxt_dint_neg;
	logic [DWORD_W-1:0] nxt_dint_value;
	logic nxt_dint_fits16;

	always_comb
	begin
		nxt_int_neg = wfd_sign_of(int_word);
		nxt_int_ext = wfd_sext16(int_word);
		nxt_dint_value = {dint_in.msw, dint_in.lsw};
		nxt_dint_neg = wfd_sign_of(dint_in.msw);
		nxt_dint_fits16 = ($signed(nxt_dint_value) <= $signed(INT16_MAX_EXT))
			&& ($signed(nxt_dint_value) >= $signed(INT16_MIN_EXT));
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			int_neg_ff <= 1'b0;
			int_ext_ff <= '0;
			dint_neg_ff <= 1'b0;
			dint_value_ff <= '0;
			dint_fits16_ff <= 1'b1;
		end
		else
		begin
			int_neg_ff <= nxt_int_neg;
			int_ext_ff <= nxt_int_ext;
			dint_neg_ff <= nxt_dint_neg;
			dint_value_ff <= nxt_dint_value;
			dint_fits16_ff <= nxt_dint_fits16;
		end
	end

	// float unpack; mantissa left-aligned in the 55-bit field
	logic [WORD_W-1:0] fp_w0;
	logic [WORD_W-1:0] fp_w1;
	logic [WORD_W-1:0] fp_w2;
	logic [WORD_W-1:0] fp_w3;
	logic [WORD_W-1:0] fp_exp_word;
	wfd_fp_fields_t nxt_fp_fields;
	logic signed [EXP_W:0] nxt_fp_exp_value;

	always_comb
	begin
		fp_w0 = fp_in[FP_W-1 -: WORD_W];
		fp_w1 = fp_in[FP_W-1-WORD_W -: WORD_W];
		fp_w2 = fp_in[FP_W-1-2*WORD_W -: WORD_W];
		fp_w3 = fp_in[WORD_W-1:0];
		fp_exp_word = fp_in_double ? fp_w3 : fp_w1;
		nxt_fp_fields.mant_sign = fp_w0[SIGN_BIT];
		nxt_fp_fields.exp_sign = fp_exp_word[EXP_SIGN_BIT];
		nxt_fp_fields.exp = fp_exp_word[EXP_MSB:EXP_LSB];
		if (fp_in_double)
			nxt_fp_fields.mant = {fp_w0[SIGN_BIT-1:0], fp_w1, fp_w2,
				fp_w3[WORD_W-1:BYTE_W]};
		else
			nxt_fp_fields.mant = {fp_w0[SIGN_BIT-1:0],
				fp_w1[WORD_W-1:BYTE_W],
				{(DP_MANT_W-SP_MANT_W){1'b0}}};
		// exponent is its own two's complement field
		nxt_fp_exp_value = {nxt_fp_fields.exp_sign,
			nxt_fp_fields.exp};
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			fp_fields_ff <= FP_FIELDS_ZERO;
			fp_exp_value_ff <= '0;
		end
		else
		begin
			fp_fields_ff <= nxt_fp_fields;
			fp_exp_value_ff <= nxt_fp_exp_value;
		end
	end

	// float pack
	logic [BYTE_W-1:0] pk_exp_byte;
	logic [FP_W-1:0] nxt_fp_packed;

	always_comb
	begin
		pk_exp_byte = {fp_pack_in.exp, fp_pack_in.exp_sign};
		if (fp_pack_double)
			nxt_fp_packed = {fp_pack_in.mant_sign,
				fp_pack_in.mant,
				pk_exp_byte};
		else
			nxt_fp_packed = {fp_pack_in.mant_sign,
				fp_pack_in.mant[DP_MANT_W-1 -: SP_MANT_W],
				pk_exp_byte, WORD_ZERO, WORD_ZERO};
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			fp_packed_ff <= '0;
		else
			fp_packed_ff <= nxt_fp_packed;
	end

	// accumulator placement of two-word values
	logic [WORD_W-1:0] nxt_acc_a;
	logic [WORD_W-1:0] nxt_acc_b;

	always_comb
	begin
		nxt_acc_a = acc_a_ff;
		nxt_acc_b = acc_b_ff;
		if (acc_load)
		begin
			if (acc_sel_fp)
			begin
				nxt_acc_a = nxt_fp_packed[FP_W-1 -: WORD_W];
				nxt_acc_b = nxt_fp_packed[FP_W-1-WORD_W -: WORD_W];
			end
			else
			begin
				nxt_acc_a = dint_in.msw;
				nxt_acc_b = dint_in.lsw;
			end
		end
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			acc_a_ff <= WORD_ZERO;
			acc_b_ff <= WORD_ZERO;
		end
		else
		begin
			acc_a_ff <= nxt_acc_a;
			acc_b_ff <= nxt_acc_b;
		end
	end
endmodule // wfd_word_format_datapath

// ==== test/wfd_byte_src.sv ====
`timescale 1ns/10ps
module wfd_byte_src (
	input wire logic clk,
	output logic rx_byte_valid,
	output logic [7:0] rx_byte
);
	initial
	begin
		rx_byte_valid = 1'b0;
		rx_byte = 8'h00;
	end
	task automatic send(input logic [15:0] w);
		@(negedge clk);
		rx_byte_valid = 1'b1;
		rx_byte = w[15:8];
		@(negedge clk);
		rx_byte = w[7:0];
		@(negedge clk);
		rx_byte_valid = 1'b0;
		// released line shows no stale byte
		rx_byte = ~rx_byte;
	endtask
	// lone byte, leaves a packer half full
	task automatic send_one(input logic [7:0] b);
		@(negedge clk);
		rx_byte_valid = 1'b1;
		rx_byte = b;
		@(negedge clk);
		rx_byte_valid = 1'b0;
		rx_byte = ~rx_byte;
	endtask
endmodule // wfd_byte_src

// ==== test/wfd_fmt_monitor.sv ====
`timescale 1ns/10ps
module wfd_fmt_monitor (
	input wire logic clk,
	input wire logic rst,
	input wire logic tx_load,
	input wire logic [15:0] tx_word,
	input wire logic tx_busy_ff,
	input wire logic tx_byte_valid_ff,
	input wire logic [7:0] tx_byte_ff,
	input wire logic pack_en,
	input wire logic rx_byte_valid,
	input wire logic [7:0] rx_byte,
	input wire logic rx_half_ff,
	input wire logic rx_word_valid_ff,
	input wire logic [15:0] rx_word_ff,
	input wire logic [15:0] int_word,
	input wire logic [31:0] int_ext_ff,
	input wire logic dint_neg_ff,
	input wire logic [31:0] dint_value_ff,
	input wire logic dint_fits16_ff
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);
	chk_tx_high_first: assert property (
		tx_load && !tx_busy_ff |=> tx_byte_valid_ff &&
		tx_byte_ff == $past(tx_word[15:8]))
		else $error("high byte not sent first");
	chk_tx_low_next: assert property (
		tx_load && !tx_busy_ff |=> ##1 tx_byte_valid_ff &&
		tx_byte_ff == $past(tx_word[7:0], 2))
		else $error("low byte not sent second");
	chk_tx_two_bytes: assert property (
		tx_byte_valid_ff ##1 tx_byte_valid_ff |=> !tx_byte_valid_ff)
		else $error("more than two bytes per word");
	chk_rx_pack_pair: assert property (
		rx_byte_valid && pack_en && rx_half_ff |=> rx_word_valid_ff &&
		rx_word_ff[7:0] == $past(rx_byte))
		else $error("packed word wrong");
	chk_rx_single_byte: assert property (
		rx_byte_valid && !pack_en |=> rx_word_valid_ff &&
		rx_word_ff == {8'h00, $past(rx_byte)})
		else $error("unpacked byte word wrong");
	chk_int_sign_ext: assert property (
		1'b1 |=> int_ext_ff == {{16{$past(int_word[15])}}, $past(int_word)})
		else $error("integer sign extension wrong");
	chk_dint_sign: assert property (
		dint_neg_ff == dint_value_ff[31])
		else $error("double sign wrong");
	chk_dint_range: assert property (
		dint_fits16_ff == (dint_value_ff[31:15] == {17{dint_value_ff[31]}}))
		else $error("single range flag wrong");
	chk_rx_pack_order: assert property (
		rx_byte_valid && pack_en && !rx_half_ff ##1
		rx_byte_valid && pack_en |=> rx_word_valid_ff &&
		rx_word_ff == {$past(rx_byte, 2), $past(rx_byte)})
		else $error("first byte not in high half");
endmodule // wfd_fmt_monitor

bind wfd_word_format_datapath wfd_fmt_monitor mon_u (.clk(clk), .rst(rst),
	.tx_load(tx_load), .tx_word(tx_word), .tx_busy_ff(tx_busy_ff),
	.tx_byte_valid_ff(tx_byte_valid_ff), .tx_byte_ff(tx_byte_ff),
	.pack_en(pack_en), .rx_byte_valid(rx_byte_valid), .rx_byte(rx_byte),
	.rx_half_ff(rx_half_ff), .rx_word_valid_ff(rx_word_valid_ff),
	.rx_word_ff(rx_word_ff), .int_word(int_word), .int_ext_ff(int_ext_ff),
	.dint_neg_ff(dint_neg_ff), .dint_value_ff(dint_value_ff),
	.dint_fits16_ff(dint_fits16_ff));

// ==== test/wfd_word_format_datapath_tb.sv ====
`timescale 1ns/10ps
`define CHK(n, e, g) \
begin \
	compares++; \
	if ((g) !== (e)) \
		$display("wrong value %s expected %h seen %h", n, e, g); \
	if ((g) !== (e)) \
		errors++; \
end
module wfd_word_format_datapath_tb;
	import wfd_pkg::*;
	logic clk, rst, tx_load, pack_en, fp_in_double, fp_pack_double;
	logic acc_load, acc_sel_fp, tx_byte_valid_ff, rx_byte_valid;
	logic tx_busy_ff, rx_half_ff;
	logic rx_word_valid_ff, int_neg_ff, dint_neg_ff, dint_fits16_ff;
	logic [7:0] tx_byte_ff, rx_byte;
	logic [15:0] tx_word, rx_word_ff, int_word, acc_a_ff, acc_b_ff;
	logic [31:0] int_ext_ff, dint_value_ff;
	logic [33:0] dint_st;
	logic [63:0] fp_in, fp_packed_ff;
	logic signed [7:0] fp_exp_value_ff;
	wfd_word_pair_t dint_in;
	wfd_fp_fields_t fp_fields_ff, fp_pack_in;
	int errors, compares, cycles;
	assign dint_st = {dint_neg_ff, dint_fits16_ff, dint_value_ff};
	wfd_word_format_datapath dut_u (.clk(clk), .rst(rst),
		.tx_load(tx_load), .tx_word(tx_word), .tx_busy_ff(tx_busy_ff),
		.tx_byte_valid_ff(tx_byte_valid_ff), .tx_byte_ff(tx_byte_ff),
		.pack_en(pack_en), .rx_byte_valid(rx_byte_valid), .rx_byte(rx_byte),
		.rx_word_valid_ff(rx_word_valid_ff), .rx_word_ff(rx_word_ff),
		.rx_half_ff(rx_half_ff), .int_word(int_word),
		.int_neg_ff(int_neg_ff),
		.int_ext_ff(int_ext_ff), .dint_in(dint_in), .dint_neg_ff(dint_neg_ff),
		.dint_value_ff(dint_value_ff), .dint_fits16_ff(dint_fits16_ff),
		.fp_in(fp_in), .fp_in_double(fp_in_double),
		.fp_fields_ff(fp_fields_ff), .fp_exp_value_ff(fp_exp_value_ff),
		.fp_pack_in(fp_pack_in), .fp_pack_double(fp_pack_double),
		.fp_packed_ff(fp_packed_ff), .acc_load(acc_load),
		.acc_sel_fp(acc_sel_fp), .acc_a_ff(acc_a_ff), .acc_b_ff(acc_b_ff));
	wfd_byte_src src_u (.clk(clk), .rx_byte_valid(rx_byte_valid),
		.rx_byte(rx_byte));
	initial
	begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	task automatic tally_and_finish();
		$display("errors %0d compares %0d", errors, compares);
		if (errors == 0 && compares > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 1000)
		begin
			errors++;
			tally_and_finish();
		end
	end
	// second load lands while busy and must be ignored
	task automatic t_tx();
		tx_word = 16'hA55A;
		tx_load = 1'b1;
		@(negedge clk);
		tx_word = 16'hFFFF;
		`CHK("tx hi", 9'h1A5, {tx_byte_valid_ff, tx_byte_ff})
		`CHK("tx busy hi", 1'b1, tx_busy_ff)
		@(negedge clk);
		tx_load = 1'b0;
		`CHK("tx lo", 9'h15A, {tx_byte_valid_ff, tx_byte_ff})
		`CHK("tx busy lo", 1'b1, tx_busy_ff)
		@(negedge clk);
		`CHK("tx idle", 1'b0, tx_byte_valid_ff)
		`CHK("tx busy idle", 1'b0, tx_busy_ff)
	endtask
	task automatic t_rx();
		pack_en = 1'b1;
		src_u.send(16'hC381);
		`CHK("rx pack", 17'h1C381, {rx_word_valid_ff, rx_word_ff})
		src_u.send_one(8'h5A);
		`CHK("rx half", 2'b10, {rx_half_ff, rx_word_valid_ff})
		pack_en = 1'b0;
		src_u.send(16'h1234);
		`CHK("rx byte", 17'h10034, {rx_word_valid_ff, rx_word_ff})
		`CHK("rx drop", 1'b0, rx_half_ff)
	endtask
	// mid-run reset, next load lands at first edge after release
	task automatic t_rst();
		rst = 1'b1;
		@(negedge clk);
		`CHK("rst fields", 64'h0, fp_fields_ff)
		`CHK("rst exp", 8'h00, fp_exp_value_ff)
		`CHK("rst acc", 32'h0, {acc_a_ff, acc_b_ff})
		`CHK("rst dint", 34'h100000000, dint_st)
		`CHK("rst tx", 2'b00, {tx_busy_ff, tx_byte_valid_ff})
		rst = 1'b0;
	endtask
	task automatic t_int();
		int_word = 16'h8000;
		@(negedge clk);
		`CHK("int min", 33'h1FFFF8000, {int_neg_ff, int_ext_ff})
		int_word = 16'h7FFF;
		@(negedge clk);
		`CHK("int max", 33'h000007FFF, {int_neg_ff, int_ext_ff})
	endtask
	task automatic t_dint();
		dint_in = '{msw: 16'h8000, lsw: 16'h0001};
		acc_sel_fp = 1'b0;
		acc_load = 1'b1;
		@(negedge clk);
		`CHK("dint", 34'h280000001, dint_st)
		`CHK("acc dint", 32'h80000001, {acc_a_ff, acc_b_ff})
		dint_in = '{msw: 16'hFFFF, lsw: 16'h8000};
		acc_load = 1'b0;
		@(negedge clk);
		`CHK("dint fit", 34'h3FFFF8000, dint_st)
	endtask
	task automatic t_fp();
		fp_in = 64'h800123FF00000000;
		fp_in_double = 1'b0;
		fp_pack_in = 64'h80012300000000FF;
		fp_pack_double = 1'b0;
		acc_sel_fp = 1'b1;
		acc_load = 1'b1;
		@(negedge clk);
		acc_load = 1'b0;
		`CHK("fp single", fp_pack_in, fp_fields_ff)
		`CHK("fp exp", 8'hFF, fp_exp_value_ff)
		`CHK("fp pack", fp_in, fp_packed_ff)
		`CHK("acc fp", fp_in[63:32], {acc_a_ff, acc_b_ff})
		fp_in = 64'h0001000200030406;
		fp_in_double = 1'b1;
		fp_pack_in = 64'h0001000200030403;
		fp_pack_double = 1'b1;
		@(negedge clk);
		`CHK("fp double", fp_pack_in, fp_fields_ff)
		`CHK("fp dpack", fp_in, fp_packed_ff)
	endtask
	initial
	begin
		rst = 1'b1;
		tx_load = 1'b0;
		tx_word = 16'h0000;
		pack_en = 1'b0;
		int_word = 16'h0000;
		dint_in = '0;
		fp_in = '0;
		fp_in_double = 1'b0;
		fp_pack_in = '0;
		fp_pack_double = 1'b0;
		acc_load = 1'b0;
		acc_sel_fp = 1'b0;
		repeat (10) @(negedge clk);
		`CHK("rst fit", 1'b1, dint_fits16_ff)
		`CHK("rst fp", 64'h0, fp_fields_ff)
		rst = 1'b0;
		@(negedge clk);
		t_tx();
		t_rx();
		t_int();
		t_dint();
		t_fp();
		t_rst();
		t_tx();
		tally_and_finish();
	end
endmodule // wfd_word_format_datapath_tb
